// *** verilog/msu_pkg.sv ***
// constants, field positions, reset values and enumerations of the multiply/shift unit.
// assumes a single core clock; the status word and control strobes come from the core sequencer.
// Operation
// - 17x17 two's-complement multiply or multiply-accumulate completes in one cycle
// - each operand is a 16-bit value with an added bit 16
// - added bit is zero for unsigned or copy of bit 15 for signed
// - product low word goes to ALU, loaded or combined into accumulator same cycle
// - product high word latched into product-high register at end of cycle
// - multiplicand comes from data memory, addressed accumulator or its offset partner
// - multiplier operand from multiplier register, or shift-value register for barrel shifts
// - shift value decodes to one-hot 16-bit operand giving a 32-bit shifted result
// - fractional shift mode shifts decoded operand one more place left
// - fractional shift mode bit is read from processor status word each operation
// - product-high, shift-value and multiplier registers load from and store to data memory
// - accumulator can move into product-high and product-high into accumulator
// - multiplier register loads long and short immediate constants from program memory
// - multiplicand register written only from data bus and never readable
// - ALU result written into one of 32 16-bit accumulator registers
// - accumulator block presents addressed register, offset partner, or both
// - ALU first input selects zero, data bus, product high, product low, offset
package msu_pkg;
	localparam int WORD_W      = 16;
	localparam int OPND_W      = 17;
	localparam int WIDE_W      = 18;
	localparam int PROD_W      = 36;
	localparam int SV_W        = 4;
	localparam int ACC_ADDR_W  = 5;
	localparam int ACC_DEPTH   = 32;
	localparam int STAT_W      = 16;
	localparam int SHORT_IMM_W = 8;
	localparam int FM_BIT      = 4;
	localparam int SIGN_BIT    = 15;
	localparam int PH_LSB      = 16;

	localparam logic [ACC_ADDR_W-1:0] ACC_OFFSET = 5'h10;
	localparam logic [WORD_W-1:0]     MR_RST     = 16'h0000;
	localparam logic [WORD_W-1:0]     PH_RST     = 16'h0000;
	localparam logic [WORD_W-1:0]     MCAND_RST  = 16'h0000;
	localparam logic [WORD_W-1:0]     ACC_RST    = 16'h0000;
	localparam logic [SV_W-1:0]       SV_RST     = 4'h0;

	typedef enum logic [1:0] {MSU_OP_NONE, MSU_OP_ALU, MSU_OP_MPY, MSU_OP_SHIFT} msu_op_type;
	typedef enum logic [1:0] {MSU_FN_LOAD, MSU_FN_ADD, MSU_FN_SUB} msu_func_type;
	typedef enum logic [1:0] {MSU_MC_DMEM, MSU_MC_ACC, MSU_MC_OFFSET} msu_mcand_type;
	typedef enum logic [2:0] {
		MSU_AF_ZERO, MSU_AF_DBUS, MSU_AF_PH, MSU_AF_PL, MSU_AF_OFFSET
	} msu_afirst_type;
	typedef enum logic [1:0] {MSU_ST_NONE, MSU_ST_PH, MSU_ST_SV, MSU_ST_MR} msu_store_type;
	typedef enum logic [1:0] {
		MSU_MRLD_NONE, MSU_MRLD_DBUS, MSU_MRLD_LONG, MSU_MRLD_SHORT
	} msu_mrld_type;
endpackage : msu_pkg

// *** verilog/msu_multiply_shift_unit.sv ***
// multiply/shift unit: 17x17 multiplier, barrel shift, product-high and accumulator block.
// assumes control inputs come from the core sequencer on mclk and are valid every cycle.
`timescale 1ns/1ns
module msu_multiply_shift_unit (
	input  wire logic                                mclk,             // core clock
	input  wire logic                                sys_rst,          // async reset, high
	input  wire msu_pkg::msu_op_type                 op,               // operation this cycle
	input  wire msu_pkg::msu_func_type               func,             // ALU combine function
	input  wire msu_pkg::msu_afirst_type             afirst_sel,       // ALU first input, alu op
	input  wire msu_pkg::msu_mcand_type              mcand_src,        // multiplicand source
	input  wire logic                                mcand_signed,     // signed multiplicand
	input  wire logic                                mplier_signed,    // signed multiplier
	input  wire logic [msu_pkg::STAT_W-1:0]          stat_word,        // processor status word
	input  wire logic [msu_pkg::ACC_ADDR_W-1:0]      acc_addr,         // addressed accumulator
	input  wire logic                                dest_offset,      // write to offset partner
	input  wire logic                                alu_b_en,         // second input = acc
	input  wire logic [msu_pkg::WORD_W-1:0]          dbus_in,          // internal data bus
	input  wire logic [msu_pkg::WORD_W-1:0]          pmem_imm,         // program memory constant
	input  wire logic                                mcand_we,         // latch multiplicand
	input  wire msu_pkg::msu_mrld_type               mr_load,          // multiplier reg load
	input  wire logic                                sv_we,            // load shift value
	input  wire logic                                ph_we_dbus,       // load ph from bus
	input  wire logic                                ph_we_acc,        // load ph from acc
	input  wire msu_pkg::msu_store_type              store_sel,        // register to store
	output logic [msu_pkg::WORD_W-1:0]               alu_result_reg,   // last ALU result
	output logic [msu_pkg::WORD_W-1:0]               acc_out_reg,      // addressed acc
	output logic [msu_pkg::WORD_W-1:0]               offset_out_reg,   // offset partner
	output logic [msu_pkg::WORD_W-1:0]               product_high_reg, // product high
	output logic [msu_pkg::WORD_W-1:0]               dbus_out_reg,     // stored value
	output logic                                     dbus_out_valid_reg // store strobe
);
	// ****************************************
	// functions
	// ****************************************
	function automatic logic [msu_pkg::OPND_W-1:0] ext17(
		input logic [msu_pkg::WORD_W-1:0] w,
		input logic                       sgn
	);
		ext17 = {sgn & w[msu_pkg::SIGN_BIT], w};
	endfunction : ext17

	// ****************************************
	// state
	// ****************************************
	logic [msu_pkg::WORD_W-1:0]     multiplier_operand_reg;
	logic [msu_pkg::SV_W-1:0]       shift_value_reg;
	logic [msu_pkg::WORD_W-1:0]     mcand_reg;
	logic [msu_pkg::WORD_W-1:0]     acc_mem [msu_pkg::ACC_DEPTH];

	logic [msu_pkg::ACC_ADDR_W-1:0] part_addr;
	logic [msu_pkg::ACC_ADDR_W-1:0] wr_addr;
	logic [msu_pkg::WORD_W-1:0]     acc_a;
	logic [msu_pkg::WORD_W-1:0]     acc_b;
	logic                           fractional_shift_mode;
	logic                           is_mult;
	logic [msu_pkg::WORD_W-1:0]     mcand_word;
	logic [msu_pkg::OPND_W-1:0]     mcand_ext;
	logic [msu_pkg::WORD_W-1:0]     shift_onehot;
	logic [msu_pkg::OPND_W-1:0]     shift_opnd;
	logic [msu_pkg::WIDE_W-1:0]     mcand_wide;
	logic [msu_pkg::WIDE_W-1:0]     mplier_wide;
	logic signed [msu_pkg::PROD_W-1:0] prod_full;
	logic [msu_pkg::WORD_W-1:0]     product_low_word;
	logic [msu_pkg::WORD_W-1:0]     prod_high;
	logic [msu_pkg::WORD_W-1:0]     alu_first_input;
	logic [msu_pkg::WORD_W-1:0]     alu_second_input;
	logic [msu_pkg::WORD_W-1:0]     alu_result_next;

	// ****************************************
	// accumulator addressing
	// ****************************************
	// the block is circular, so the partner is +16 mod 32 in both halves
	assign part_addr = acc_addr ^ msu_pkg::ACC_OFFSET;
	assign wr_addr   = dest_offset ? part_addr : acc_addr;
	assign acc_a     = acc_mem[acc_addr];
	assign acc_b     = acc_mem[part_addr];

	// ****************************************
	// multiplier datapath
	// ****************************************
	assign fractional_shift_mode = stat_word[msu_pkg::FM_BIT];
	assign is_mult = (op == msu_pkg::MSU_OP_MPY) || (op == msu_pkg::MSU_OP_SHIFT);

	always_comb begin
		unique case (mcand_src)
			msu_pkg::MSU_MC_ACC:    mcand_word = acc_a;
			msu_pkg::MSU_MC_OFFSET: mcand_word = acc_b;
			default:                mcand_word = mcand_reg;
		endcase
	end

	assign mcand_ext    = ext17(mcand_word, mcand_signed);
	assign shift_onehot = 16'h0001 << shift_value_reg;
	// fractional mode moves the one-hot bit up one place, possibly into bit 16
	assign shift_opnd   = fractional_shift_mode ? {shift_onehot, 1'b0}
	                                            : {1'b0, shift_onehot};

	// one guard bit keeps a shift operand with bit 16 set positive
	assign mcand_wide  = {mcand_ext[msu_pkg::OPND_W-1], mcand_ext};
	assign mplier_wide = (op == msu_pkg::MSU_OP_SHIFT) ? {1'b0, shift_opnd}
	                   : {1'b0, ext17(multiplier_operand_reg, mplier_signed)} |
	                     {mplier_signed & multiplier_operand_reg[msu_pkg::SIGN_BIT],
	                      {msu_pkg::OPND_W{1'b0}}};

	assign prod_full        = $signed(mcand_wide) * $signed(mplier_wide);
	assign product_low_word = prod_full[msu_pkg::WORD_W-1:0];
	assign prod_high        = prod_full[msu_pkg::PH_LSB +: msu_pkg::WORD_W];

	// ****************************************
	// ALU
	// ****************************************
	always_comb begin
		if (is_mult) begin
			alu_first_input = product_low_word;
		end else begin
			unique case (afirst_sel)
				msu_pkg::MSU_AF_DBUS:   alu_first_input = dbus_in;
				msu_pkg::MSU_AF_PH:     alu_first_input = product_high_reg;
				msu_pkg::MSU_AF_PL:     alu_first_input = product_low_word;
				msu_pkg::MSU_AF_OFFSET: alu_first_input = acc_b;
				default:                alu_first_input = '0;
			endcase
		end
	end

	assign alu_second_input = alu_b_en ? acc_a : '0;

	always_comb begin
		unique case (func)
			msu_pkg::MSU_FN_ADD: alu_result_next = alu_second_input + alu_first_input;
			msu_pkg::MSU_FN_SUB: alu_result_next = alu_second_input - alu_first_input;
			default:             alu_result_next = alu_first_input;
		endcase
	end

	// ****************************************
	// accumulator block
	// ****************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < msu_pkg::ACC_DEPTH; i++) begin
				acc_mem[i] <= msu_pkg::ACC_RST;
			end
		end else if (op != msu_pkg::MSU_OP_NONE) begin
			acc_mem[wr_addr] <= alu_result_next;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			alu_result_reg <= msu_pkg::ACC_RST;
			acc_out_reg    <= msu_pkg::ACC_RST;
			offset_out_reg <= msu_pkg::ACC_RST;
		end else begin
			if (op != msu_pkg::MSU_OP_NONE) begin
				alu_result_reg <= alu_result_next;
			end
			acc_out_reg    <= acc_a;
			offset_out_reg <= acc_b;
		end
	end

	// ****************************************
	// multiplier registers
	// ****************************************
	// a multiply owns the product-high register in its cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			product_high_reg <= msu_pkg::PH_RST;
		end else if (is_mult) begin
			product_high_reg <= prod_high;
		end else if (ph_we_acc) begin
			product_high_reg <= acc_a;
		end else if (ph_we_dbus) begin
			product_high_reg <= dbus_in;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			multiplier_operand_reg <= msu_pkg::MR_RST;
		end else begin
			unique case (mr_load)
				msu_pkg::MSU_MRLD_DBUS:  multiplier_operand_reg <= dbus_in;
				msu_pkg::MSU_MRLD_LONG:  multiplier_operand_reg <= pmem_imm;
				msu_pkg::MSU_MRLD_SHORT: multiplier_operand_reg <=
					{{(msu_pkg::WORD_W-msu_pkg::SHORT_IMM_W){1'b0}},
					 pmem_imm[msu_pkg::SHORT_IMM_W-1:0]};
				default:                 multiplier_operand_reg <= multiplier_operand_reg;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_value_reg <= msu_pkg::SV_RST;
		end else if (sv_we) begin
			shift_value_reg <= dbus_in[msu_pkg::SV_W-1:0];
		end
	end

	// write-only: no store path reads this register; it reaches outputs only through the multiplier
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mcand_reg <= msu_pkg::MCAND_RST;
		end else if (mcand_we) begin
			mcand_reg <= dbus_in;
		end
	end

	// ****************************************
	// store path to data memory
	// ****************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dbus_out_reg       <= '0;
			dbus_out_valid_reg <= 1'b0;
		end else begin
			dbus_out_valid_reg <= (store_sel != msu_pkg::MSU_ST_NONE);
			unique case (store_sel)
				msu_pkg::MSU_ST_PH: dbus_out_reg <= product_high_reg;
				msu_pkg::MSU_ST_SV: dbus_out_reg <=
					{{(msu_pkg::WORD_W-msu_pkg::SV_W){1'b0}}, shift_value_reg};
				msu_pkg::MSU_ST_MR: dbus_out_reg <= multiplier_operand_reg;
				default:            dbus_out_reg <= dbus_out_reg;
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	logic [31:0] uref;
	logic [31:0] sref;
	logic [31:0] shref;
	assign uref  = {16'h0000, mcand_reg} * {16'h0000, multiplier_operand_reg};
	assign sref  = {{16{mcand_reg[15]}}, mcand_reg} *
	               {{16{multiplier_operand_reg[15]}}, multiplier_operand_reg};
	assign shref = fractional_shift_mode ? ({16'h0000, mcand_reg} << (shift_value_reg + 5'h01))
	                                     : ({16'h0000, mcand_reg} << shift_value_reg);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_unsigned_mpy;
		(op == msu_pkg::MSU_OP_MPY && mcand_src == msu_pkg::MSU_MC_DMEM && !mcand_signed
		 && !mplier_signed && func == msu_pkg::MSU_FN_LOAD && !mcand_we
		 && mr_load == msu_pkg::MSU_MRLD_NONE)
		|=> {product_high_reg, alu_result_reg} == $past(uref);
	endproperty
	a_unsigned_mpy: assert property (p_unsigned_mpy) else $error("unsigned product wrong");

	property p_signed_mpy;
		(op == msu_pkg::MSU_OP_MPY && mcand_src == msu_pkg::MSU_MC_DMEM && mcand_signed
		 && mplier_signed && func == msu_pkg::MSU_FN_LOAD)
		|=> product_high_reg == $past(sref[31:16]) && alu_result_reg == $past(sref[15:0]);
	endproperty
	a_signed_mpy: assert property (p_signed_mpy) else $error("signed product wrong");

	property p_shift_plain;
		(op == msu_pkg::MSU_OP_SHIFT && mcand_src == msu_pkg::MSU_MC_DMEM && !mcand_signed
		 && func == msu_pkg::MSU_FN_LOAD)
		|=> {product_high_reg, alu_result_reg} == $past(shref);
	endproperty
	a_shift_plain: assert property (p_shift_plain) else $error("barrel shift wrong");

	property p_mac_add;
		(op == msu_pkg::MSU_OP_MPY && func == msu_pkg::MSU_FN_ADD && alu_b_en && !dest_offset)
		|=> alu_result_reg == 16'($past(acc_a) + $past(product_low_word))
		    && acc_mem[$past(acc_addr)] == alu_result_reg;
	endproperty
	a_mac_add: assert property (p_mac_add) else $error("accumulate wrong");

	property p_acc_write;
		(op != msu_pkg::MSU_OP_NONE) |=> acc_mem[$past(wr_addr)] == alu_result_reg;
	endproperty
	a_acc_write: assert property (p_acc_write) else $error("accumulator not written");

	property p_partner_read;
		1'b1 |=> offset_out_reg == $past(acc_mem[acc_addr ^ 5'h10]) && acc_out_reg == $past(acc_a);
	endproperty
	a_partner_read: assert property (p_partner_read) else $error("operand read wrong");

	property p_ph_to_acc;
		(op == msu_pkg::MSU_OP_ALU && afirst_sel == msu_pkg::MSU_AF_PH && func == msu_pkg::MSU_FN_LOAD)
		|=> alu_result_reg == $past(product_high_reg);
	endproperty
	a_ph_to_acc: assert property (p_ph_to_acc) else $error("ph to ALU wrong");

	property p_acc_to_ph;
		(!is_mult && ph_we_acc) |=> product_high_reg == $past(acc_a);
	endproperty
	a_acc_to_ph: assert property (p_acc_to_ph) else $error("acc to ph wrong");

	property p_short_imm;
		(mr_load == msu_pkg::MSU_MRLD_SHORT)
		|=> multiplier_operand_reg == {8'h00, $past(pmem_imm[7:0])};
	endproperty
	a_short_imm: assert property (p_short_imm) else $error("short constant wrong");

	property p_mcand_hold;
		!mcand_we |=> $stable(mcand_reg);
	endproperty
	a_mcand_hold: assert property (p_mcand_hold) else $error("multiplicand changed");

	property p_store_ph;
		(store_sel == msu_pkg::MSU_ST_PH)
		|=> dbus_out_valid_reg && dbus_out_reg == $past(product_high_reg);
	endproperty
	a_store_ph: assert property (p_store_ph) else $error("ph store wrong");

	property p_store_sv;
		(store_sel == msu_pkg::MSU_ST_SV)
		|=> dbus_out_valid_reg && dbus_out_reg == {12'h000, $past(shift_value_reg)};
	endproperty
	a_store_sv: assert property (p_store_sv) else $error("sv store wrong");

	property p_store_idle;
		(store_sel == msu_pkg::MSU_ST_NONE) |=> !dbus_out_valid_reg && $stable(dbus_out_reg);
	endproperty
	a_store_idle: assert property (p_store_idle) else $error("idle store moved");

	property p_dbus_to_ph;
		(!is_mult && !ph_we_acc && ph_we_dbus) |=> product_high_reg == $past(dbus_in);
	endproperty
	a_dbus_to_ph: assert property (p_dbus_to_ph) else $error("bus to ph wrong");

	property p_mr_long;
		(mr_load == msu_pkg::MSU_MRLD_LONG) |=> multiplier_operand_reg == $past(pmem_imm);
	endproperty
	a_mr_long: assert property (p_mr_long) else $error("long constant wrong");

	property p_alu_sub;
		(op == msu_pkg::MSU_OP_ALU && func == msu_pkg::MSU_FN_SUB && alu_b_en
		 && afirst_sel == msu_pkg::MSU_AF_DBUS)
		|=> alu_result_reg == 16'($past(acc_a) - $past(dbus_in));
	endproperty
	a_alu_sub: assert property (p_alu_sub) else $error("subtract wrong");

	c_frac_shift: cover property (op == msu_pkg::MSU_OP_SHIFT && fractional_shift_mode);
	c_mac:        cover property (op == msu_pkg::MSU_OP_MPY && func == msu_pkg::MSU_FN_ADD);
	c_store_mr:   cover property (store_sel == msu_pkg::MSU_ST_MR ##1 dbus_out_valid_reg);
	c_signed_mpy: cover property (op == msu_pkg::MSU_OP_MPY && mcand_signed && mplier_signed);
	c_acc_to_ph:  cover property (!is_mult && ph_we_acc);
endmodule : msu_multiply_shift_unit

// *** tb/msu_dmem_model.sv ***
// data memory side of the multiply/shift unit: keeps the last word stored back from the unit and counts the stores.
// assumes the store strobe is a one-cycle pulse sampled on mclk.
`timescale 1ns/1ns
module msu_dmem_model (
	input  wire logic        mclk,        // core clock
	input  wire logic        sys_rst,     // async reset, high
	input  wire logic        store_en,    // store strobe from unit
	input  wire logic [15:0] store_data,  // stored word
	output logic [15:0]      mem_word,    // last word written to memory
	output int               store_count  // words written so far
);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_word    <= 16'h0000;
			store_count <= 0;
		end else if (store_en) begin
			mem_word    <= store_data;
			store_count <= store_count + 1;
		end
	end
endmodule : msu_dmem_model

// *** tb/test_msu_multiply_shift_unit.sv ***
// self-checking bench of the multiply/shift unit against an integer model.
// assumes one 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module test_msu_multiply_shift_unit;
	logic mclk = 0, sys_rst = 1, mcand_signed, mplier_signed, dest_offset, alu_b_en;
	logic mcand_we, sv_we, ph_we_dbus, ph_we_acc, dv;
	msu_pkg::msu_op_type op;
	msu_pkg::msu_func_type func;
	msu_pkg::msu_afirst_type afirst_sel;
	msu_pkg::msu_mcand_type mcand_src;
	msu_pkg::msu_mrld_type mr_load;
	msu_pkg::msu_store_type store_sel;
	logic [15:0] stat_word, dbus_in, pmem_imm, res, aout, oout, ph, dout, mem_word;
	logic [4:0]  acc_addr;
	logic [15:0] m_acc [32];
	logic [15:0] m_mr, m_ph, m_mc, m_res, m_aout, m_oout, m_dout;
	logic [3:0]  m_sv;
	logic        m_dv;
	int num_errors = 0, check_count = 0, exp_stores = 0, cycles = 0, store_count;
	always #10 mclk = ~mclk;
	msu_multiply_shift_unit u_msu_multiply_shift_unit (.mclk(mclk), .sys_rst(sys_rst),
		.op(op), .func(func), .afirst_sel(afirst_sel), .mcand_src(mcand_src),
		.mcand_signed(mcand_signed), .mplier_signed(mplier_signed), .stat_word(stat_word),
		.acc_addr(acc_addr), .dest_offset(dest_offset), .alu_b_en(alu_b_en),
		.dbus_in(dbus_in), .pmem_imm(pmem_imm), .mcand_we(mcand_we), .mr_load(mr_load),
		.sv_we(sv_we), .ph_we_dbus(ph_we_dbus), .ph_we_acc(ph_we_acc),
		.store_sel(store_sel), .alu_result_reg(res), .acc_out_reg(aout),
		.offset_out_reg(oout), .product_high_reg(ph), .dbus_out_reg(dout),
		.dbus_out_valid_reg(dv));
	msu_dmem_model u_msu_dmem_model (.mclk(mclk), .sys_rst(sys_rst), .store_en(dv),
		.store_data(dout), .mem_word(mem_word), .store_count(store_count));
	// ****************************************
	// compare and close
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic compare_all();
		check(res, m_res);
		check(ph, m_ph);
		check(aout, m_aout);
		check(oout, m_oout);
		check({15'h0000, dv}, {15'h0000, m_dv});
		check(dout, m_dout);
	endtask : compare_all
	// ****************************************
	// model step: all next values from old state
	// ****************************************
	task automatic run_cycle();
		longint a, b, p;
		logic [15:0] src, first, accv, r;
		logic [4:0] part;
		@(posedge mclk);
		part = acc_addr ^ 5'h10;
		case (mcand_src)
			msu_pkg::MSU_MC_DMEM: src = m_mc;
			msu_pkg::MSU_MC_ACC:  src = m_acc[acc_addr];
			default:              src = m_acc[part];
		endcase
		a = mcand_signed ? longint'($signed(src)) : longint'(src);
		b = mplier_signed ? longint'($signed(m_mr)) : longint'(m_mr);
		if (op == msu_pkg::MSU_OP_SHIFT)
			b = longint'(1) << (int'(m_sv) + int'(stat_word[msu_pkg::FM_BIT]));
		p = a * b;
		case (afirst_sel)
			msu_pkg::MSU_AF_ZERO: first = 16'h0000;
			msu_pkg::MSU_AF_DBUS: first = dbus_in;
			msu_pkg::MSU_AF_PH:   first = m_ph;
			msu_pkg::MSU_AF_PL:   first = p[15:0];
			default:              first = m_acc[part];
		endcase
		if (op == msu_pkg::MSU_OP_MPY || op == msu_pkg::MSU_OP_SHIFT)
			first = p[15:0];
		accv = alu_b_en ? m_acc[acc_addr] : 16'h0000;
		r = (func == msu_pkg::MSU_FN_LOAD) ? first :
			(func == msu_pkg::MSU_FN_ADD) ? accv + first : accv - first;
		m_aout = m_acc[acc_addr];
		m_oout = m_acc[part];
		m_dv = (store_sel != msu_pkg::MSU_ST_NONE);
		if (m_dv) begin
			exp_stores++;
			m_dout = (store_sel == msu_pkg::MSU_ST_PH) ? m_ph :
				(store_sel == msu_pkg::MSU_ST_SV) ? {12'h000, m_sv} : m_mr;
		end
		if (op == msu_pkg::MSU_OP_MPY || op == msu_pkg::MSU_OP_SHIFT)
			m_ph = p[31:16];
		else if (ph_we_acc)
			m_ph = m_acc[acc_addr];
		else if (ph_we_dbus)
			m_ph = dbus_in;
		if (op != msu_pkg::MSU_OP_NONE) begin
			m_res = r;
			m_acc[dest_offset ? part : acc_addr] = r;
		end
		if (mcand_we)
			m_mc = dbus_in;
		if (sv_we)
			m_sv = dbus_in[3:0];
		case (mr_load)
			msu_pkg::MSU_MRLD_DBUS:  m_mr = dbus_in;
			msu_pkg::MSU_MRLD_LONG:  m_mr = pmem_imm;
			msu_pkg::MSU_MRLD_SHORT: m_mr = {8'h00, pmem_imm[7:0]};
			default: ;
		endcase
		@(negedge mclk);
		compare_all();
	endtask : run_cycle
	task automatic idle();
		op         = msu_pkg::MSU_OP_NONE;
		func       = msu_pkg::MSU_FN_LOAD;
		afirst_sel = msu_pkg::MSU_AF_ZERO;
		mcand_src  = msu_pkg::MSU_MC_DMEM;
		mr_load    = msu_pkg::MSU_MRLD_NONE;
		store_sel  = msu_pkg::MSU_ST_NONE;
		{mcand_signed, mplier_signed, dest_offset, alu_b_en, mcand_we} = '0;
		{sv_we, ph_we_dbus, ph_we_acc} = '0;
		{stat_word, acc_addr, dbus_in, pmem_imm} = '0;
	endtask : idle
	// ****************************************
	// main sequence
	// ****************************************
	task automatic mpy(input logic [15:0] x, input logic [15:0] y, input logic sg);
		idle(); mcand_we = 1; dbus_in = x; mr_load = msu_pkg::MSU_MRLD_LONG; pmem_imm = y;
		run_cycle();
		idle(); op = msu_pkg::MSU_OP_MPY; mcand_signed = sg; mplier_signed = sg;
		acc_addr = 5'h03; alu_b_en = 1; func = msu_pkg::MSU_FN_ADD;
		run_cycle();
	endtask : mpy
	initial begin
		idle();
		foreach (m_acc[i]) m_acc[i] = 16'h0000;
		{m_mr, m_ph, m_mc, m_res, m_aout, m_oout, m_dout, m_sv, m_dv} = '0;
		void'($urandom(32'h0861b617));
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		compare_all();
		mpy(16'hffff, 16'hffff, 0);
		mpy(16'h8000, 16'h8000, 1);
		mpy(16'h7fff, 16'h8001, 1);
		idle(); mr_load = msu_pkg::MSU_MRLD_SHORT; pmem_imm = 16'habcd; run_cycle();
		for (int s = 0; s < 4; s++) begin
			idle(); sv_we = 1; dbus_in = (s < 2) ? 16'h000f : 16'h0007; run_cycle();
			idle(); op = msu_pkg::MSU_OP_SHIFT; mcand_src = msu_pkg::MSU_MC_OFFSET;
			mcand_signed = s[0]; stat_word[msu_pkg::FM_BIT] = s[0]; acc_addr = 5'h13;
			run_cycle();
		end
		repeat (600) begin
			op = msu_pkg::msu_op_type'($urandom_range(3, 0));
			func = msu_pkg::msu_func_type'($urandom_range(2, 0));
			afirst_sel = msu_pkg::msu_afirst_type'($urandom_range(4, 0));
			mcand_src = msu_pkg::msu_mcand_type'($urandom_range(2, 0));
			mr_load = msu_pkg::msu_mrld_type'($urandom_range(3, 0));
			store_sel = msu_pkg::msu_store_type'($urandom_range(3, 0));
			{mcand_signed, mplier_signed, dest_offset, alu_b_en} = 4'($urandom);
			{mcand_we, sv_we, ph_we_dbus, ph_we_acc} = 4'($urandom);
			{stat_word, dbus_in} = $urandom;
			pmem_imm = 16'($urandom);
			acc_addr = 5'($urandom);
			run_cycle();
		end
		idle();
		run_cycle();
		check(mem_word, m_dout);
		check(16'(store_count), 16'(exp_stores));
		close_out();
	end
endmodule : test_msu_multiply_shift_unit
